// ---- core/psu_ctrl_pkg.sv ----
/*
 psu_ctrl_pkg: shared constants of the supply control and status logic.
 assumes a single 200 MHz core clock and a 32-bit APB register bus.
*/
package psu_ctrl_pkg;
   // clock and timing
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned HALF_SEC_MS = 500;
   localparam int unsigned HALF_SEC_CYCLES = CLK_MHZ * 1000 * HALF_SEC_MS;
   localparam int unsigned SYNC_W = 10;
   // share trim limit, millivolts
   localparam logic [7:0] TRIM_MAX_MV = 8'hfa;
   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h00c;
   // ctrl fields
   localparam int unsigned CTRL_SOFT_OFF_BIT = 0;
   localparam int unsigned CTRL_FAN_MAX_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // status fields
   localparam int unsigned ST_MAIN_ON_BIT = 0;
   localparam int unsigned ST_GOOD_BIT = 1;
   localparam int unsigned ST_FAULT_BIT = 2;
   localparam int unsigned ST_RANGE_BIT = 3;
   localparam int unsigned ST_WARN_BIT = 4;
   localparam int unsigned ST_KILL_BIT = 5;
   localparam int unsigned ST_SYSF_BIT = 6;
   // interrupt event fields
   localparam int unsigned EV_W = 5;
   localparam int unsigned EV_FAULT_BIT = 0;
   localparam int unsigned EV_WARN_BIT = 1;
   localparam int unsigned EV_KILL_BIT = 2;
   localparam int unsigned EV_SYSF_BIT = 3;
   localparam int unsigned EV_GOOD_LOST_BIT = 4;
   localparam logic [4:0] IRQ_RESET = 5'h00;
   // led patterns
   typedef enum {LED_OFF, LED_STBY_BLINK, LED_GOOD, LED_WARN_ALT, LED_FAIL} led_mode_t;
endpackage

// ---- core/half_second_tick.sv ----
/*
 half_second_tick: free-running divider giving a one-cycle enable pulse.
 assumes the core clock; the period is a parameter so benches can shorten it.
*/
`timescale 1ns/1ps
`default_nettype none
module half_second_tick
#(
   parameter int unsigned PERIOD = 100
)
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   output logic o_tick
);
   logic [31:0] count_reg;

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         count_reg <= 32'h0;
         o_tick <= 1'b0;
      end
      else if (count_reg >= 32'(PERIOD - 1))
      begin
         count_reg <= 32'h0;
         o_tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule // half_second_tick
`default_nettype wire

// ---- core/psu_control_status_logic.sv ----
/*
 psu_control_status_logic: enable gating, fault latch, status pins,
 bi-colour led, fan boost, share bus release and an APB register file.
 assumes pin levels are asynchronous and are synchronised here; the share
 trim request comes from the share controller on the same clock.
*/
// How it works
// - led dark without line power, fault or warning
// - standby only: green flashes at 1 Hz
// - green when output good, yellow on failure
// - warning alternates yellow and green half second
// - kill input high switches main off
// - standby rail enabled whenever reset is released
// - main auto-on with line in range, enable low
// - line-in-range output active high
// - main only while enable input low
// - enable toggle clears latched faults
// - boost request low forces fan, not standby
// - alert low while problem present
// - outputs good needs both rails in regulation
// - system fault high shuts output down
// - share pin released on fault or off
// - largest current is master; slave trim limited
`timescale 1ns/1ps
`default_nettype none
module psu_control_status_logic
#(
   parameter int unsigned HALF_SEC_CYCLES = psu_ctrl_pkg::HALF_SEC_CYCLES
)
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_unplug_kill_pin,
   input wire logic i_main_output_enable_pin,
   input wire logic i_fan_boost_request_n,
   input wire logic i_system_fault_shutdown_in,
   input wire logic i_line_present,
   input wire logic i_line_in_range,
   input wire logic i_standby_rail_good,
   input wire logic i_main_rail_good,
   input wire logic i_fault_trip,
   input wire logic i_warning,
   input wire logic i_share_largest,
   input wire logic [7:0] i_share_trim_req_mv,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_main_output_on,
   output logic o_standby_rail_on,
   output logic o_line_in_range_out,
   output logic o_outputs_good_out,
   output logic o_attention_alert_n,
   output logic o_led_green,
   output logic o_led_yellow,
   output logic o_fan_max,
   output logic o_share_connect,
   output logic o_share_master,
   output logic [7:0] o_share_trim_mv,
   output logic o_irq,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: stage one feeds stage two only
   localparam int unsigned SW = psu_ctrl_pkg::SYNC_W;
   logic [SW-1:0] pins_raw;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;

   assign pins_raw = {i_warning, i_fault_trip, i_main_rail_good, i_standby_rail_good,
                      i_line_in_range, i_line_present, i_system_fault_shutdown_in,
                      i_fan_boost_request_n, i_main_output_enable_pin, i_unplug_kill_pin};

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         // inactive levels: enable and boost high, all else low
         sync1_reg <= 10'h006;
         sync2_reg <= 10'h006;
      end
      else
      begin
         sync1_reg <= pins_raw;
         sync2_reg <= sync1_reg;
      end
   end

   logic kill_s, en_n_s, boost_n_s, sysf_s, line_s, range_s;
   logic sb_good_s, main_good_s, trip_s, warn_s;
   assign {warn_s, trip_s, main_good_s, sb_good_s, range_s, line_s,
           sysf_s, boost_n_s, en_n_s, kill_s} = sync2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // control register and fault latch
   logic [1:0] ctrl_reg;
   logic fault_latched_reg;
   logic en_prev_reg;
   logic en_toggle;
   logic wr_en, rd_en;

   assign en_toggle = en_n_s != en_prev_reg;

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         en_prev_reg <= 1'b1;
      else
         en_prev_reg <= en_n_s;
   end

   // a trip in the same cycle as the toggle keeps the latch set
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         fault_latched_reg <= 1'b0;
      else if (trip_s)
         fault_latched_reg <= 1'b1;
      else if (en_toggle)
         fault_latched_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // main output gating
   logic main_on_next;
   logic good_next;
   logic failure;
   logic standby_only;

   // floating enable reads high, so a bare pin keeps main off
   assign main_on_next = line_s && range_s && sb_good_s
                         && !en_n_s
                         && !kill_s
                         && !sysf_s
                         && !fault_latched_reg && !trip_s
                         && !ctrl_reg[psu_ctrl_pkg::CTRL_SOFT_OFF_BIT];
   assign good_next = main_on_next && main_good_s && sb_good_s;
   assign failure = fault_latched_reg || trip_s;
   assign standby_only = line_s && !main_on_next;

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_main_output_on <= 1'b0;
         o_outputs_good_out <= 1'b0;
         o_standby_rail_on <= 1'b0;
         o_line_in_range_out <= 1'b0;
         o_attention_alert_n <= 1'b1;
      end
      else
      begin
         o_main_output_on <= main_on_next;
         o_outputs_good_out <= good_next;
         o_standby_rail_on <= 1'b1;
         o_line_in_range_out <= line_s && range_s;
         o_attention_alert_n <= !(failure || warn_s || sysf_s);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fan and current share
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_fan_max <= 1'b0;
         o_share_connect <= 1'b0;
         o_share_master <= 1'b0;
         o_share_trim_mv <= 8'h00;
      end
      else
      begin
         // boost request only counts with main running
         o_fan_max <= (main_on_next && !boost_n_s)
                      || ctrl_reg[psu_ctrl_pkg::CTRL_FAN_MAX_BIT];
         o_share_connect <= main_on_next && !failure;
         o_share_master <= main_on_next && i_share_largest;
         if (!main_on_next || i_share_largest)
            o_share_trim_mv <= 8'h00;
         else if (i_share_trim_req_mv > psu_ctrl_pkg::TRIM_MAX_MV)
            o_share_trim_mv <= psu_ctrl_pkg::TRIM_MAX_MV;
         else
            o_share_trim_mv <= i_share_trim_req_mv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status led
   logic tick;
   logic phase_reg;
   psu_ctrl_pkg::led_mode_t led_mode;

   half_second_tick #(.PERIOD(HALF_SEC_CYCLES)) u_tick
   (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .o_tick(tick)
   );

   // one phase per half second gives the 1 Hz patterns
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         phase_reg <= 1'b0;
      else if (tick)
         phase_reg <= !phase_reg;
   end

   always_comb
   begin
      if (failure)
         led_mode = psu_ctrl_pkg::LED_FAIL;
      else if (warn_s)
         led_mode = psu_ctrl_pkg::LED_WARN_ALT;
      else if (good_next)
         led_mode = psu_ctrl_pkg::LED_GOOD;
      else if (standby_only)
         led_mode = psu_ctrl_pkg::LED_STBY_BLINK;
      else
         led_mode = psu_ctrl_pkg::LED_OFF;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_led_green <= 1'b0;
         o_led_yellow <= 1'b0;
      end
      else
      begin
         unique case (led_mode)
            psu_ctrl_pkg::LED_OFF:
            begin
               o_led_green <= 1'b0;
               o_led_yellow <= 1'b0;
            end
            psu_ctrl_pkg::LED_STBY_BLINK:
            begin
               o_led_green <= phase_reg;
               o_led_yellow <= 1'b0;
            end
            psu_ctrl_pkg::LED_GOOD:
            begin
               o_led_green <= 1'b1;
               o_led_yellow <= 1'b0;
            end
            psu_ctrl_pkg::LED_WARN_ALT:
            begin
               o_led_green <= !phase_reg;
               o_led_yellow <= phase_reg;
            end
            psu_ctrl_pkg::LED_FAIL:
            begin
               o_led_green <= 1'b0;
               o_led_yellow <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt events
   localparam int unsigned EW = psu_ctrl_pkg::EV_W;
   logic [EW-1:0] lvl, lvl_prev_reg, events;
   logic [EW-1:0] irq_stat_reg, irq_mask_reg, w1c;

   assign lvl = {!good_next, sysf_s, kill_s, warn_s, fault_latched_reg};
   assign events = lvl & ~lvl_prev_reg;
   assign w1c = (wr_en && i_paddr == psu_ctrl_pkg::IRQ_STAT_OFS) ? i_pwdata[EW-1:0] : '0;

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         lvl_prev_reg <= 5'h1f;
         irq_stat_reg <= psu_ctrl_pkg::IRQ_RESET;
         o_irq <= 1'b0;
      end
      else
      begin
         lvl_prev_reg <= lvl;
         // a new event outranks a write-one-to-clear in the same cycle
         irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
         o_irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer registered
   function automatic logic mapped(input logic [11:0] a);
      mapped = a == psu_ctrl_pkg::CTRL_OFS || a == psu_ctrl_pkg::STATUS_OFS
               || a == psu_ctrl_pkg::IRQ_STAT_OFS || a == psu_ctrl_pkg::IRQ_MASK_OFS;
   endfunction

   logic [31:0] rdata;
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite && mapped(i_paddr);
   assign rd_en = i_psel && i_penable && !o_pready;

   always_comb
   begin
      rdata = 32'h0;
      unique case (i_paddr)
         psu_ctrl_pkg::CTRL_OFS: rdata[1:0] = ctrl_reg;
         psu_ctrl_pkg::STATUS_OFS:
            rdata[6:0] = {sysf_s, kill_s, warn_s, range_s, fault_latched_reg,
                          o_outputs_good_out, o_main_output_on};
         psu_ctrl_pkg::IRQ_STAT_OFS: rdata[EW-1:0] = irq_stat_reg;
         psu_ctrl_pkg::IRQ_MASK_OFS: rdata[EW-1:0] = irq_mask_reg;
         default: rdata = 32'h0;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= rd_en;
         o_pslverr <= rd_en && !mapped(i_paddr);
         if (rd_en && !i_pwrite)
            o_prdata <= rdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ctrl_reg <= psu_ctrl_pkg::CTRL_RESET;
         irq_mask_reg <= psu_ctrl_pkg::IRQ_RESET;
      end
      else if (wr_en)
      begin
         if (i_paddr == psu_ctrl_pkg::CTRL_OFS)
            ctrl_reg <= i_pwdata[1:0];
         if (i_paddr == psu_ctrl_pkg::IRQ_MASK_OFS)
            irq_mask_reg <= i_pwdata[EW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   kill_forces_off_a: assert property (kill_s |=> !o_main_output_on)
      else $error("main on while kill high");
   standby_stays_a: assert property ($past(i_nrst) |-> o_standby_rail_on)
      else $error("standby rail dropped");
   auto_turn_on_a: assert property (
      (line_s && range_s && sb_good_s && !en_n_s && !kill_s && !sysf_s && !trip_s
       && !fault_latched_reg && ctrl_reg == 2'h0) |=> o_main_output_on)
      else $error("main did not turn on");
   range_out_a: assert property (o_line_in_range_out == $past(line_s && range_s))
      else $error("line range output wrong");
   enable_low_a: assert property (o_main_output_on |-> $past(!en_n_s))
      else $error("main on with enable high");
   toggle_clears_a: assert property (
      (en_toggle && !trip_s) ##1 (!trip_s && !en_toggle) |-> !fault_latched_reg)
      else $error("fault latch not cleared");
   fan_boost_a: assert property (
      (!main_on_next && !ctrl_reg[psu_ctrl_pkg::CTRL_FAN_MAX_BIT]) |=> !o_fan_max)
      else $error("fan forced in standby");
   alert_low_a: assert property ($rose(fault_latched_reg) |=> !o_attention_alert_n)
      else $error("alert not asserted on fault");
   good_rails_a: assert property (
      o_outputs_good_out |-> $past(main_good_s && sb_good_s))
      else $error("good without both rails");
   good_needs_main_a: assert property (o_outputs_good_out |-> o_main_output_on)
      else $error("good while main disabled");
   sys_fault_off_a: assert property (sysf_s [*2] |-> !o_main_output_on)
      else $error("main on during system fault");
   share_release_a: assert property (
      o_share_connect |-> (o_main_output_on && !$past(failure)))
      else $error("share pin connected while off");
   trim_limit_a: assert property (
      o_share_trim_mv <= psu_ctrl_pkg::TRIM_MAX_MV && !(o_share_master && o_share_trim_mv != 8'h00))
      else $error("share trim out of range");
   led_fail_a: assert property ($past(failure) |-> (o_led_yellow && !o_led_green))
      else $error("failure not shown yellow");
   led_dark_a: assert property (
      $past(!line_s && !failure && !warn_s) |-> !(o_led_green || o_led_yellow))
      else $error("led lit without line");
   led_phase_a: assert property (
      $past(led_mode == psu_ctrl_pkg::LED_WARN_ALT) |-> o_led_yellow == $past(phase_reg))
      else $error("warning pattern wrong");
   irq_set_wins_a: assert property ((|events) |=> (|irq_stat_reg))
      else $error("event lost");

   auto_on_c: cover property ($rose(o_main_output_on));
   fault_clear_c: cover property ($fell(fault_latched_reg));
   warn_blink_c: cover property (led_mode == psu_ctrl_pkg::LED_WARN_ALT && tick);
   irq_c: cover property ($rose(o_irq));
endmodule // psu_control_status_logic
`default_nettype wire

// ---- sim/psu_host_board_model.sv ----
/*
 psu_host_board_model: system board side of the supply's control pins.
 assumes open-drain drivers on the board; the pull-ups sit in the supply.
*/
`timescale 1ns/1ps
`default_nettype none
module psu_host_board_model
(
   input wire logic i_seated,
   input wire logic i_pull_enable_low,
   input wire logic i_pull_boost_low,
   input wire logic i_fault_drive,
   output logic o_unplug_kill_pin,
   output logic o_main_output_enable_pin,
   output logic o_fan_boost_request_n,
   output logic o_system_fault_shutdown_in
);
   // kill pin grounded while seated, pulled high once withdrawn
   assign o_unplug_kill_pin = !i_seated;
   // released enable floats to the pull-up, so main stays off
   assign o_main_output_enable_pin = i_pull_enable_low ? 1'b0 : 1'b1;
   assign o_fan_boost_request_n = i_pull_boost_low ? 1'b0 : 1'b1;
   assign o_system_fault_shutdown_in = i_fault_drive;
endmodule // psu_host_board_model
`default_nettype wire

// ---- sim/psu_control_status_logic_test.sv ----
/*
 psu_control_status_logic_test: self-checking bench for the supply logic.
 assumes the board model on the pins and a shortened blink period.
*/
`timescale 1ns/1ps
`default_nettype none
module psu_control_status_logic_test;
   typedef struct packed {logic [7:0] pins; logic [5:0] exp; logic led_chk;} row_t;
   logic core_clk, nrst, seated, pull_en_low, pull_boost_low, fault_drive;
   logic line_present, line_in_range, sb_good, main_good, trip, warning, largest;
   logic kill_pin, en_pin, boost_n, sysf_pin;
   logic [7:0] trim_req;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic main_on, sb_on, range_out, good, alert_n, led_g, led_y, fan_max;
   logic share_conn, share_master, irq, err;
   logic [7:0] trim;
   logic [5:0] obs;
   int errors, compares;
   // pins: kill, enable_n, sysfault, line, range, sb good, main good, warning
   // exp: main, good, range, alert_n, green, yellow
   localparam row_t rows [8] = '{
      '{8'b0000_0100, 6'b000100, 1'b1}, '{8'b0001_1110, 6'b111110, 1'b1},
      '{8'b0001_1100, 6'b101100, 1'b0}, '{8'b1001_1110, 6'b001100, 1'b0},
      '{8'b0101_1110, 6'b001100, 1'b0}, '{8'b0011_1110, 6'b001000, 1'b0},
      '{8'b0001_0110, 6'b000100, 1'b0}, '{8'b0001_1111, 6'b111000, 1'b0}};
   assign obs = {main_on, good, range_out, alert_n, led_g, led_y};
   psu_host_board_model u_psu_host_board_model (.i_seated(seated),
      .i_pull_enable_low(pull_en_low), .i_pull_boost_low(pull_boost_low),
      .i_fault_drive(fault_drive), .o_unplug_kill_pin(kill_pin),
      .o_main_output_enable_pin(en_pin), .o_fan_boost_request_n(boost_n),
      .o_system_fault_shutdown_in(sysf_pin));
   psu_control_status_logic #(.HALF_SEC_CYCLES(16)) u_psu_control_status_logic (
      .i_core_clk(core_clk), .i_nrst(nrst), .i_unplug_kill_pin(kill_pin),
      .i_main_output_enable_pin(en_pin), .i_fan_boost_request_n(boost_n),
      .i_system_fault_shutdown_in(sysf_pin), .i_line_present(line_present),
      .i_line_in_range(line_in_range), .i_standby_rail_good(sb_good),
      .i_main_rail_good(main_good), .i_fault_trip(trip), .i_warning(warning),
      .i_share_largest(largest), .i_share_trim_req_mv(trim_req), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_main_output_on(main_on), .o_standby_rail_on(sb_on),
      .o_line_in_range_out(range_out), .o_outputs_good_out(good),
      .o_attention_alert_n(alert_n), .o_led_green(led_g), .o_led_yellow(led_y),
      .o_fan_max(fan_max), .o_share_connect(share_conn), .o_share_master(share_master),
      .o_share_trim_mv(trim), .o_irq(irq), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr));
   always #2.5 core_clk = !core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         compares++;
         if (seen !== exp)
         begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task conclude();
      begin
         $display("checks %0d mismatches %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // pin changes need 3 edges to show; a few spare edges cover it
   task settle();
      begin
         repeat (6) @(posedge core_clk);
         @(negedge core_clk);
      end
   endtask
   task set_pins(input logic [7:0] v);
      begin
         @(posedge core_clk);
         seated <= !v[7];
         pull_en_low <= !v[6];
         fault_drive <= v[5];
         line_present <= v[4];
         line_in_range <= v[3];
         sb_good <= v[2];
         main_good <= v[1];
         warning <= v[0];
         settle();
      end
   endtask
   // request held until pready is sampled high; only the watchdog ends a hang
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      begin
         @(posedge core_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge core_clk);
         penable <= 1'b1;
         @(posedge core_clk);
         while (pready !== 1'b1)
            @(posedge core_clk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task blink(input logic warn);
      begin
         // a stuck led never leaves these loops and trips the watchdog
         while (led_g !== 1'b0)
            @(negedge core_clk);
         while (led_g !== 1'b1)
            @(negedge core_clk);
         repeat (15) @(negedge core_clk);
         check({led_g, led_y}, {1'b1, 1'b0});
         @(negedge core_clk);
         check({led_g, led_y}, {1'b0, warn});
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #60000;
      errors++;
      conclude();
   end
   initial
   begin
      {core_clk, nrst, pull_en_low, pull_boost_low, fault_drive, line_present} = '0;
      {line_in_range, sb_good, main_good, trip, warning, largest} = '0;
      {psel, penable, pwrite, paddr, pwdata, trim_req} = '0;
      seated = 1'b1;
      errors = 0;
      compares = 0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      check({main_on, good, alert_n, sb_on}, 4'b0010);
      $display("reset done");
      @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         set_pins(rows[i].pins);
         check(obs[5:2], rows[i].exp[5:2]);
         if (rows[i].led_chk)
            check(obs[1:0], rows[i].exp[1:0]);
         check(sb_on, 1'b1);
         $display("row %0d done", i);
      end
      set_pins(8'b0101_1110);
      blink(1'b0);
      set_pins(8'b0001_1111);
      blink(1'b1);
      $display("led blink done");
      @(posedge core_clk);
      trip <= 1'b1;
      repeat (3) @(posedge core_clk);
      trip <= 1'b0;
      settle();
      check({main_on, led_g, led_y, alert_n, share_conn}, 5'b00100);
      repeat (17) @(negedge core_clk);
      check({main_on, led_g, led_y}, 3'b001);
      set_pins(8'b0101_1110);
      set_pins(8'b0001_1110);
      check({main_on, good, led_g, led_y}, 4'b1110);
      $display("latched fault done");
      @(posedge core_clk);
      pull_boost_low <= 1'b1;
      settle();
      check(fan_max, 1'b1);
      set_pins(8'b0101_1110);
      check(fan_max, 1'b0);
      @(posedge core_clk);
      pull_boost_low <= 1'b0;
      set_pins(8'b0001_1110);
      @(posedge core_clk);
      largest <= 1'b1;
      trim_req <= 8'h64;
      settle();
      check({share_conn, share_master, trim}, {2'b11, 8'h00});
      @(posedge core_clk);
      largest <= 1'b0;
      settle();
      check({share_conn, share_master, trim}, {2'b10, 8'h64});
      @(posedge core_clk);
      trim_req <= 8'hff;
      settle();
      check(trim, psu_ctrl_pkg::TRIM_MAX_MV);
      set_pins(8'b0101_1110);
      check({share_conn, share_master, trim}, 10'h000);
      set_pins(8'b0001_1110);
      $display("fan and share done");
      apb(1'b0, psu_ctrl_pkg::STATUS_OFS, 32'h0);
      check(err, 1'b0);
      check(rd, 32'h0000000b);
      // soft off and forced fan from the control register
      apb(1'b1, psu_ctrl_pkg::CTRL_OFS, 32'h3);
      settle();
      check({main_on, good, fan_max}, 3'b001);
      apb(1'b0, psu_ctrl_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h3);
      apb(1'b1, psu_ctrl_pkg::CTRL_OFS, 32'h0);
      settle();
      check({main_on, good, fan_max}, 3'b110);
      apb(1'b1, psu_ctrl_pkg::IRQ_STAT_OFS, 32'h1f);
      apb(1'b1, psu_ctrl_pkg::IRQ_MASK_OFS, 32'h1 << psu_ctrl_pkg::EV_KILL_BIT);
      apb(1'b0, psu_ctrl_pkg::IRQ_MASK_OFS, 32'h0);
      check(rd, 32'h1 << psu_ctrl_pkg::EV_KILL_BIT);
      settle();
      check(irq, 1'b0);
      set_pins(8'b1001_1110);
      check({irq, main_on, good}, 3'b100);
      apb(1'b0, psu_ctrl_pkg::IRQ_STAT_OFS, 32'h0);
      check(rd, (32'h1 << psu_ctrl_pkg::EV_KILL_BIT) | (32'h1 << psu_ctrl_pkg::EV_GOOD_LOST_BIT));
      apb(1'b1, psu_ctrl_pkg::IRQ_STAT_OFS, 32'h1 << psu_ctrl_pkg::EV_KILL_BIT);
      settle();
      check(irq, 1'b0);
      apb(1'b0, psu_ctrl_pkg::IRQ_STAT_OFS, 32'h0);
      check(rd, 32'h1 << psu_ctrl_pkg::EV_GOOD_LOST_BIT);
      apb(1'b0, 12'h010, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      $display("register access done");
      // mid-run reset: outputs drop at once, standby returns one edge after release
      @(posedge core_clk);
      nrst <= 1'b0;
      @(negedge core_clk);
      check({main_on, good, alert_n, sb_on, irq}, 5'b00100);
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(negedge core_clk);
      check({sb_on, main_on}, 2'b10);
      set_pins(8'b0001_1110);
      check({main_on, good}, 2'b11);
      $display("mid-run reset done");
      conclude();
   end
endmodule // psu_control_status_logic_test
`default_nettype wire
